// file: common/bdt_defines.svh
// Register map, field positions, reset values and sizes of the transmit DMA control block.
// Assumes it is included by bare name from the package and the verification modules.
`ifndef BDT_DEFINES_SVH
`define BDT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------------------
`define BDT_OFF_CTRL 16'h9000
`define BDT_OFF_PTR 16'h9008
`define BDT_OFF_STAT 16'h9014

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define BDT_BRST_HI 4
`define BDT_BIT_STSKO 5
`define BDT_BIT_CCPIE 7
`define BDT_BIT_NLIE 8
`define BDT_BIT_NOIE 9
`define BDT_BIT_EMPTY 10
`define BDT_THR_HI 13
`define BDT_THR_LO 11
`define BDT_BIT_EN 14
`define BDT_BIT_RS 15
`define BDT_CTRL_MASK 16'h7FBF
`define BDT_CTRL_RST 16'h0000
`define BDT_PTR_RST 32'hFFFFFFFF
`define BDT_NULL_PTR 30'h00000000

// ----------------------------------------------------------------------------
// Status register fields and sizes
// ----------------------------------------------------------------------------
`define BDT_STAT_BUSY 8
`define BDT_STAT_FEED 9
`define BDT_BUF_WORDS 7'h40
`define BDT_THR_STEP 7'h08
`define BDT_THR_MAX 7'h20
`define BDT_DESC_WORDS 6'h03
`define BDT_OWN_BIT 31

`endif

// file: common/bdt_pkg.sv
// Types shared by the transmit DMA control block and its output buffer.
// Assumes the defines header sits beside it on the include path.
`include "bdt_defines.svh"

package bdt_pkg;

  // ----------------------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    BDT_IDLE = 3'b000,
    BDT_DESC_REQ = 3'b001,
    BDT_DESC_DATA = 3'b010,
    BDT_CHECK = 3'b011,
    BDT_DATA_REQ = 3'b100,
    BDT_DATA_DATA = 3'b101
  } bdt_state_t;

  // One buffered word: end-of-frame flag above 32 data bits.
  typedef logic [32:0] bdt_word_t;

endpackage

// file: common/bdt_stream_if.sv
// Valid/ready word stream between the transmit engine and its output buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface bdt_stream_if;
  import bdt_pkg::*;
  logic valid;
  logic ready;
  bdt_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: rtl/bdt_tx_skid.sv
// Two-entry buffer between the transmit engine and the MAC transmit FIFO.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module bdt_tx_skid (
  input wire logic pclk,
  input wire logic presetn,
  bdt_stream_if.snk up,
  bdt_stream_if.src dn
);
  import bdt_pkg::*;

  typedef struct packed {
    bdt_word_t e0;
    bdt_word_t e1;
    logic [1:0] cnt;
  } bdt_skid_st_t;

  bdt_skid_st_t s_q;
  bdt_skid_st_t s_d;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------------
  // Ready depends only on occupancy, so a stalled MAC simply fills both entries.
  assign up.ready = (s_q.cnt != 2'h2);
  assign dn.valid = (s_q.cnt != 2'h0);
  assign dn.data = s_q.e0;
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // Entry 0 is always the head; entry 1 shifts down when the head leaves.
  always_comb begin
    s_d = s_q;
    if (pop) begin
      s_d.e0 = s_q.e1;
    end
    if (push) begin
      if ((s_q.cnt == 2'h0) || ((s_q.cnt == 2'h1) && pop)) begin
        s_d.e0 = up.data;
      end else begin
        s_d.e1 = up.data;
      end
    end
    s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: rtl/bdt_tx_control.sv
// Transmit half of a buffered Ethernet DMA engine: APB registers, descriptor walk,
// burst fetch into a 64-word transmit buffer, threshold-gated feed to the MAC FIFO.
// Assumes a memory read port that grants a request and then returns mem_len beats,
// and a MAC FIFO with valid/ready on the same clock.
// Descriptor: word 0 = owner (bit 31, 1 = DMA) and buffer address, word 1 = length
// in words (bits 15:0), word 2 = next descriptor address.
`timescale 1ns/1ps

module bdt_tx_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [5:0] mem_len,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata,
  output logic mac_valid,
  input wire logic mac_ready,
  output logic [31:0] mac_data,
  output logic mac_last,
  input wire logic mac_tx_en,
  input wire logic mac_ctrl_done,
  output logic irq_ctrl_done,
  output logic irq_null_list,
  output logic irq_not_owner,
  output logic irq_buf_empty
);
  import bdt_pkg::*;

  typedef struct packed {
    bdt_state_t st;
    logic [15:0] ctrl;
    logic [31:0] ptr;
    logic [31:0] rdata;
    logic req;
    logic [31:0] addr;
    logic [5:0] len;
    logic [5:0] beats;
    logic [1:0] dbeat;
    logic [31:0] dbuf;
    logic [15:0] dlen;
    logic [31:0] dnext;
    logic [15:0] remain;
    logic first;
    logic feed;
    logic [63:0][32:0] mem;
    logic [5:0] wptr;
    logic [5:0] rptr;
    logic [6:0] level;
    logic irq_cd;
    logic irq_nl;
    logic irq_no;
    logic irq_be;
  } bdt_ctl_st_t;

  bdt_ctl_st_t s_q;
  bdt_ctl_st_t s_d;
  bdt_stream_if up ();
  bdt_stream_if dn ();
  logic acc;
  logic hit;
  logic push;
  logic pop;
  logic [6:0] thr_words;
  logic [5:0] blen;
  logic [6:0] space;

  // ----------------------------------------------------------------------------
  // Output buffer towards the MAC FIFO
  // ----------------------------------------------------------------------------
  bdt_tx_skid u_skid (
    .pclk(pclk),
    .presetn(presetn),
    .up(up),
    .dn(dn)
  );

  // Data comes from the buffer's own flip-flops; the handshake is the buffer's.
  assign mac_valid = dn.valid;
  assign mac_data = dn.data[31:0];
  assign mac_last = dn.data[32];
  assign dn.ready = mac_ready;
  assign up.data = s_q.mem[s_q.rptr];
  // Draining ignores the enable bit, so a disable strands buffered words only while the threshold gate is still closed.
  assign up.valid = (s_q.level != 7'h00) && s_q.feed && mac_tx_en;
  assign pop = up.valid && up.ready;

  // ----------------------------------------------------------------------------
  // APB decode and plain outputs
  // ----------------------------------------------------------------------------
  assign acc = psel && penable;
  assign hit = (paddr[15:0] == `BDT_OFF_CTRL) || (paddr[15:0] == `BDT_OFF_PTR) ||
               (paddr[15:0] == `BDT_OFF_STAT);
  assign pready = acc;
  assign pslverr = acc && !hit;
  assign prdata = s_q.rdata;
  assign mem_req = s_q.req;
  assign mem_addr = s_q.addr;
  assign mem_len = s_q.len;
  assign irq_ctrl_done = s_q.irq_cd;
  assign irq_null_list = s_q.irq_nl;
  assign irq_not_owner = s_q.irq_no;
  assign irq_buf_empty = s_q.irq_be;

  // Threshold in words: the 64-word buffer in eighths, any code with bit 2 set means half.
  always_comb begin
    if (s_q.ctrl[`BDT_THR_HI]) begin
      thr_words = `BDT_THR_MAX;
    end else begin
      thr_words = 7'(s_q.ctrl[`BDT_THR_HI-1:`BDT_THR_LO] * `BDT_THR_STEP);
    end
  end

  // Burst length is the field plus one, trimmed to what is left of the frame.
  always_comb begin
    blen = {1'b0, s_q.ctrl[`BDT_BRST_HI:0]} + 6'h01;
    if ({10'h000, blen} > s_q.remain) begin
      blen = s_q.remain[5:0];
    end
    space = `BDT_BUF_WORDS - s_q.level;
  end

  assign push = (s_q.st == BDT_DATA_DATA) && mem_rvalid;

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.irq_cd = mac_ctrl_done && s_q.ctrl[`BDT_BIT_CCPIE];
    s_d.irq_nl = 1'b0;
    s_d.irq_no = 1'b0;
    s_d.irq_be = 1'b0;

    // Read data is captured in the setup phase so the access phase answers at once.
    if (psel && !penable) begin
      s_d.rdata = 32'h00000000;
      if (paddr[15:0] == `BDT_OFF_CTRL) begin
        s_d.rdata = {16'h0000, s_q.ctrl & `BDT_CTRL_MASK};
      end else if (paddr[15:0] == `BDT_OFF_PTR) begin
        s_d.rdata = s_q.ptr;
      end else if (paddr[15:0] == `BDT_OFF_STAT) begin
        s_d.rdata[6:0] = s_q.level;
        s_d.rdata[`BDT_STAT_BUSY] = (s_q.st != BDT_IDLE);
        s_d.rdata[`BDT_STAT_FEED] = s_q.feed;
      end
    end

    // Fetch engine.
    unique case (s_q.st)
      BDT_IDLE: begin
        if (s_q.ctrl[`BDT_BIT_EN]) begin
          if (s_q.ptr[31:2] == `BDT_NULL_PTR) begin
            s_d.irq_nl = s_q.ctrl[`BDT_BIT_NLIE];
            s_d.ctrl[`BDT_BIT_EN] = 1'b0;
          end else begin
            s_d.st = BDT_DESC_REQ;
            s_d.req = 1'b1;
            s_d.addr = {s_q.ptr[31:2], 2'b00};
            s_d.len = `BDT_DESC_WORDS;
            s_d.dbeat = 2'h0;
          end
        end
      end
      BDT_DESC_REQ: begin
        if (mem_gnt) begin
          s_d.req = 1'b0;
          s_d.st = BDT_DESC_DATA;
        end
      end
      BDT_DESC_DATA: begin
        if (mem_rvalid) begin
          s_d.dbeat = s_q.dbeat + 2'h1;
          if (s_q.dbeat == 2'h0) begin
            s_d.dbuf = mem_rdata;
          end else if (s_q.dbeat == 2'h1) begin
            s_d.dlen = mem_rdata[15:0];
          end else begin
            s_d.dnext = mem_rdata;
            s_d.st = BDT_CHECK;
          end
        end
      end
      BDT_CHECK: begin
        if (s_q.dbuf[`BDT_OWN_BIT]) begin
          s_d.remain = s_q.dlen;
          s_d.addr = {1'b0, s_q.dbuf[30:2], 2'b00};
          s_d.first = 1'b1;
          if (s_q.dlen == 16'h0000) begin
            s_d.ptr = s_q.dnext;
            s_d.st = BDT_IDLE;
          end else begin
            s_d.st = BDT_DATA_REQ;
          end
        end else if (s_q.ctrl[`BDT_BIT_STSKO]) begin
          s_d.irq_no = s_q.ctrl[`BDT_BIT_NOIE];
          s_d.ctrl[`BDT_BIT_EN] = 1'b0;
          s_d.st = BDT_IDLE;
        end else begin
          s_d.ptr = s_q.dnext;
          s_d.st = BDT_IDLE;
        end
      end
      BDT_DATA_REQ: begin
        if (!s_q.ctrl[`BDT_BIT_EN] && !s_q.req) begin
          s_d.st = BDT_IDLE;
        end else if (s_q.req) begin
          if (mem_gnt) begin
            s_d.req = 1'b0;
            s_d.beats = s_q.len;
            s_d.st = BDT_DATA_DATA;
          end
        end else if (space >= {1'b0, blen}) begin
          // Waiting for room means every word of a granted burst has a slot.
          s_d.req = 1'b1;
          s_d.len = blen;
        end
      end
      BDT_DATA_DATA: begin
        if (mem_rvalid) begin
          s_d.addr = s_q.addr + 32'h00000004;
          s_d.remain = s_q.remain - 16'h0001;
          s_d.beats = s_q.beats - 6'h01;
          s_d.first = 1'b0;
          if (s_q.beats == 6'h01) begin
            if (s_q.remain == 16'h0001) begin
              s_d.ptr = s_q.dnext;
              s_d.st = BDT_IDLE;
            end else begin
              s_d.st = BDT_DATA_REQ;
            end
          end
        end
      end
      default: begin
        s_d.st = BDT_IDLE;
      end
    endcase

    // Transmit buffer: push from memory, pop into the output buffer.
    if (push) begin
      s_d.mem[s_q.wptr] = {(s_q.remain == 16'h0001), mem_rdata};
      s_d.wptr = s_q.wptr + 6'h01;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + 6'h01;
    end
    s_d.level = s_q.level + {6'h00, push} - {6'h00, pop};

    // The gate closes only when a frame starts into an empty buffer, so the tail of
    // the previous frame is never held back by the next one.
    if (push && s_q.first && (s_q.level == 7'h00) && (thr_words != 7'h00)) begin
      s_d.feed = 1'b0;
    end
    if (s_d.level >= thr_words) begin
      s_d.feed = 1'b1;
    end
    if (push && (s_q.remain == 16'h0001)) begin
      s_d.feed = 1'b1;
    end
    if ((s_q.level != 7'h00) && (s_d.level == 7'h00)) begin
      s_d.irq_be = s_q.ctrl[`BDT_BIT_EMPTY];
    end

    // Register writes land on the access phase; software has the last word on enable.
    if (acc && pwrite) begin
      if (paddr[15:0] == `BDT_OFF_CTRL) begin
        s_d.ctrl = pwdata[15:0] & `BDT_CTRL_MASK;
      end else if (paddr[15:0] == `BDT_OFF_PTR) begin
        s_d.ptr = pwdata;
      end
      if ((paddr[15:0] == `BDT_OFF_CTRL) && pwdata[`BDT_BIT_RS]) begin
        // Engine reset drops the fetch and the transmit buffer's words, not those already in the output buffer; the mask keeps bit 15 at 0.
        s_d.st = BDT_IDLE;
        s_d.req = 1'b0;
        s_d.wptr = 6'h00;
        s_d.rptr = 6'h00;
        s_d.level = 7'h00;
        s_d.feed = 1'b1;
        s_d.first = 1'b0;
        s_d.irq_be = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= `BDT_CTRL_RST;
      s_q.ptr <= `BDT_PTR_RST;
      s_q.feed <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: verification/bdt_properties.sv
// Checker for the transmit DMA control block, bound to its top module.
// Assumes software's control writes are visible at the APB ports.
`timescale 1ns/1ps
`include "bdt_defines.svh"

module bdt_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [5:0] mem_len,
  input wire logic mem_gnt,
  input wire logic mac_valid,
  input wire logic mac_ready,
  input wire logic [31:0] mac_data,
  input wire logic mac_last,
  input wire logic mac_ctrl_done,
  input wire logic irq_ctrl_done,
  input wire logic irq_null_list,
  input wire logic irq_not_owner,
  input wire logic irq_buf_empty
);
  logic [31:0] ctl_q;
  logic wr_ctl;

  // Hardware only clears enable, so a shadow of written values judges the other bits.
  assign wr_ctl = psel && penable && pwrite && paddr[15:0] == `BDT_OFF_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 32'h0;
    end else if (wr_ctl) begin
      ctl_q <= pwdata;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_stall;
    mac_valid && !mac_ready;
  endsequence

  chk_unmapped_err: assert property (s_acc |-> pslverr == !(paddr[15:0] inside
    {`BDT_OFF_CTRL, `BDT_OFF_PTR, `BDT_OFF_STAT})) else $error("pslverr wrong");
  chk_reserved_zero: assert property ((s_acc and (!pwrite && paddr[15:0] == `BDT_OFF_CTRL))
    |-> (prdata & 32'hFFFF8040) == 32'h0) else $error("reserved bits read back");
  chk_burst_len: assert property ($rose(mem_req) |-> mem_len == 6'h03 ||
    mem_len <= {1'b0, ctl_q[4:0]} + 6'h01) else $error("burst too long");
  chk_req_holds: assert property (mem_req && !mem_gnt && !(wr_ctl && pwdata[15])
    |=> mem_req && $stable(mem_addr) && $stable(mem_len)) else $error("request dropped");
  chk_fetch_on: assert property ($rose(mem_req) |-> ctl_q[14])
    else $error("fetch while off");
  chk_mac_hold: assert property (s_stall |=> mac_valid && $stable(mac_data)
    && $stable(mac_last)) else $error("stalled word changed");
  chk_ctrl_done: assert property (irq_ctrl_done == ($past(mac_ctrl_done) && $past(ctl_q[7])))
    else $error("ctrl done irq wrong");
  chk_null_gate: assert property (irq_null_list |-> ctl_q[8])
    else $error("null irq ungated");
  chk_owner_gate: assert property (irq_not_owner |-> ctl_q[9] && ctl_q[5])
    else $error("owner irq ungated");
  chk_empty_gate: assert property (irq_buf_empty |-> ctl_q[10])
    else $error("empty irq ungated");
endmodule

bind bdt_tx_control bdt_properties i_chk (.*);

// file: verification/bdt_far_model.sv
// Far side of the block: system memory read port and MAC transmit FIFO sink.
// Assumes the bench fills desc and drains rx_q; other addresses return a pattern.
`timescale 1ns/1ps

module bdt_far_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [5:0] mem_len,
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata,
  input wire logic mac_valid,
  output logic mac_ready,
  input wire logic [31:0] mac_data,
  input wire logic mac_last,
  input wire logic stall,
  input wire logic slow
);
  logic [31:0] desc [logic [31:0]];
  logic [32:0] rx_q [$];
  logic [31:0] a;
  int beats = 0;
  int n;

  // One burst at a time; slow mode delays the grant and spaces the beats.
  // Idle data lines carry the inverse of the last word, except after a slow burst, where they settle back on that word.
  initial begin
    mem_gnt = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdata = 32'h0;
    forever begin
      @(posedge pclk);
      if (presetn && mem_req) begin
        if (slow) repeat (3) @(posedge pclk);
        a = mem_addr;
        n = mem_len;
        mem_gnt <= 1'b1;
        @(posedge pclk);
        mem_gnt <= 1'b0;
        for (int i = 0; i < n; i++) begin
          mem_rvalid <= 1'b1;
          mem_rdata <= desc.exists(a) ? desc[a] : a ^ 32'h5A5A0000;
          a = a + 32'h4;
          beats++;
          @(posedge pclk);
          if (slow) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            @(posedge pclk);
          end
        end
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
    end
  end

  // Ready follows the bench's stall switch; taken words queue for the bench.
  assign mac_ready = !stall;
  always @(posedge pclk) begin
    if (presetn && mac_valid && mac_ready) begin
      rx_q.push_back({mac_last, mac_data});
    end
  end
endmodule

// file: verification/bdt_tx_control_bench.sv
// Self-checking bench for the transmit DMA control block.
// Assumes the far-side model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`include "bdt_defines.svh"

module bdt_tx_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic mac_tx_en = 1'b1;
  logic mac_ctrl_done = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [31:0] prdata, mem_addr, mem_rdata, mac_data, r;
  logic [5:0] mem_len;
  logic pready, pslverr, mem_req, mem_gnt, mem_rvalid, mac_valid, mac_ready, mac_last, err;
  logic irq_ctrl_done, irq_null_list, irq_not_owner, irq_buf_empty;
  int miscompares = 0;
  int checks_done = 0;
  int ic [4] = '{0, 0, 0, 0};
  int first_at = 0;
  int b0 = 0;

  always #20 pclk = ~pclk;

  bdt_tx_control i_dut (.*);
  bdt_far_model i_far (.*);

  // Pulses are tallied so scenarios compare counts rather than exact moments.
  always @(posedge pclk) begin
    ic[0] += int'(irq_ctrl_done);
    ic[1] += int'(irq_null_list);
    ic[2] += int'(irq_not_owner);
    ic[3] += int'(irq_buf_empty);
    if (mac_valid && first_at < 0) begin
      first_at = i_far.beats - b0;
    end
  end

  task automatic check(input string nm, input logic [32:0] s, input logic [32:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; an idle edge follows so the next setup never collides.
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {16'h0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic put_desc(input logic [31:0] a, w0, n, nx);
    i_far.desc[a] = w0;
    i_far.desc[a + 32'h4] = n;
    i_far.desc[a + 32'h8] = nx;
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 3000 && i_far.rx_q.size() < n; i++) begin
      @(posedge pclk);
    end
    check("mac words", i_far.rx_q.size(), n);
  endtask

  task automatic pop_frame(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      check("mac word", i_far.rx_q.pop_front(),
            {i == n - 1, (b + 32'(4 * i)) ^ 32'h5A5A0000});
    end
  endtask

  task automatic wait_off();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, `BDT_OFF_CTRL, 32'h0);
      if (r[14] === 1'b0) break;
    end
  endtask

  task automatic t_regs();
    apb(1'b0, `BDT_OFF_CTRL, 32'h0);
    check("ctrl reset", r, 32'h0);
    apb(1'b0, `BDT_OFF_PTR, 32'h0);
    check("ptr reset", r, 32'hFFFFFFFF);
    apb(1'b1, `BDT_OFF_CTRL, 32'hFFFFBFFF);
    apb(1'b0, `BDT_OFF_CTRL, 32'h0);
    check("ctrl mask", r, 32'h00003FBF);
    apb(1'b0, 16'h9004, 32'h0);
    check("unmapped", {err, r}, 33'h100000000);
  endtask

  // A foreign frame between two owned ones is skipped; the null next pointer stops the walk.
  task automatic t_chain();
    put_desc(32'h100, 32'h80000200, 32'h5, 32'h110);
    put_desc(32'h110, 32'h00000300, 32'h2, 32'h120);
    put_desc(32'h120, 32'h80000400, 32'h3, 32'h0);
    stall <= 1'b1;
    apb(1'b1, `BDT_OFF_PTR, 32'h100);
    apb(1'b1, `BDT_OFF_CTRL, 32'h6501);
    repeat (40) @(posedge pclk);
    stall <= 1'b0;
    wait_rx(8);
    pop_frame(32'h200, 5);
    pop_frame(32'h400, 3);
    wait_off();
    check("auto off", r, 32'h2501);
    check("null irq", ic[1], 1);
    check("empty irq", ic[3] > 0, 1);
    apb(1'b1, `BDT_OFF_PTR, 32'h110);
    apb(1'b1, `BDT_OFF_CTRL, 32'h4220);
    wait_off();
    check("stop ctrl", r, 32'h0220);
    check("owner irq", ic[2], 1);
  endtask

  // Slow memory lets the gate level show: no word leaves before the set fill.
  task automatic t_thr();
    put_desc(32'h140, 32'h80001000, 32'h28, 32'h0);
    slow <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      first_at = -1;
      // The three descriptor words must not count toward the fill level.
      b0 = i_far.beats + 3;
      apb(1'b1, `BDT_OFF_PTR, 32'h140);
      apb(1'b1, `BDT_OFF_CTRL, 32'h401F | 32'(c << 11));
      wait_rx(40);
      pop_frame(32'h1000, 40);
      check("gate level", first_at >= 8 * (c > 3 ? 4 : c), 1);
      wait_off();
    end
    slow <= 1'b0;
  endtask

  // With the MAC off nothing leaves; an engine reset mid-frame then drops the buffered words.
  task automatic t_soft();
    put_desc(32'h180, 32'h80002000, 32'h10, 32'h0);
    mac_tx_en <= 1'b0;
    apb(1'b1, `BDT_OFF_PTR, 32'h180);
    apb(1'b1, `BDT_OFF_CTRL, 32'h4000);
    repeat (30) @(posedge pclk);
    check("mac off", i_far.rx_q.size(), 0);
    apb(1'b0, `BDT_OFF_STAT, 32'h0);
    check("buffered", r[6:0] != 7'h00, 1);
    apb(1'b1, `BDT_OFF_CTRL, 32'h8000);
    apb(1'b0, `BDT_OFF_STAT, 32'h0);
    check("soft reset status", r, 32'h00000200);
    mac_tx_en <= 1'b1;
    repeat (10) @(posedge pclk);
    check("no stale words", i_far.rx_q.size(), 0);
  endtask

  task automatic t_done();
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, `BDT_OFF_CTRL, 32'(e << 7));
      mac_ctrl_done <= 1'b1;
      @(posedge pclk);
      mac_ctrl_done <= 1'b0;
      repeat (3) @(posedge pclk);
      check("ctrl done irq", ic[0], e);
    end
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_chain();
    t_thr();
    t_soft();
    t_done();
    complete_run();
  end

  // Hang guard, well beyond the thousand or so cycles the scenarios need.
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    complete_run();
  end
endmodule
